// ---- dqc_axis.sv ----
// One quadrature axis: synchroniser, edge decode and wrapping up/down counter.
`timescale 1ns/10ps
module dqc_axis #(
  parameter int CNT_W = dqc_pkg::DQC_CNT_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Encoder side
  input wire dqc_pkg::dqc_phase_s phase,
  input wire logic clear,
  // Result
  output logic [CNT_W-1:0] count,
  output logic step
);
  import dqc_pkg::*;

  if (CNT_W < 9 || CNT_W > 12) begin : g_bad_width
    $error("dqc_axis: CNT_W must lie in 9..12");
  end

  dqc_phase_s sync1;
  dqc_phase_s sync2;
  dqc_phase_s prev;
  logic up;
  logic down;

  // ==========================================================================
  // Input synchroniser
  // ==========================================================================
  // two flop synchroniser
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else begin
      sync1 <= phase;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  // ==========================================================================
  // Direction decode
  // ==========================================================================
  // A leads B counts up
  always_comb begin
    up = 1'b0;
    down = 1'b0;
    if (sync2.phase_a != prev.phase_a && sync2.phase_b == prev.phase_b) begin
      up = (sync2.phase_a != sync2.phase_b);
      down = (sync2.phase_a == sync2.phase_b);
    end else if (sync2.phase_b != prev.phase_b && sync2.phase_a == prev.phase_a) begin
      up = (sync2.phase_a == sync2.phase_b);
      down = (sync2.phase_a != sync2.phase_b);
    end
  end

  // ==========================================================================
  // Counter
  // ==========================================================================
  // clear while high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= CNT_W'(DQC_CNT_RST);
    end else if (clear) begin
      count <= CNT_W'(DQC_CNT_RST);
    end else if (up) begin
      count <= count + 1'b1;
    end else if (down) begin
      count <= count - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      step <= 1'b0;
    end else begin
      step <= up | down;
    end
  end

  a_count_up: assert property (@(posedge clock) disable iff (!rstn)
    (up && !clear) |=> count == $past(count) + 1'b1) else $error("count did not rise");
  a_clear_zero: assert property (@(posedge clock) disable iff (!rstn)
    clear |=> count == '0) else $error("clear did not zero count");
  a_idle_hold: assert property (@(posedge clock) disable iff (!rstn)
    (!up && !down && !clear) |=> $stable(count)) else $error("count moved without edge");
  a_wrap_down: assert property (@(posedge clock) disable iff (!rstn)
    (down && !clear && count == '0) |=> &count) else $error("down wrap failed");
endmodule

// ---- dqc_enc_model.sv ----
// Two-phase encoder model that drives one axis of the counter.
`timescale 1ns/10ps
module dqc_enc_model (
  // Clock
  input wire logic clock,
  // Encoder phases
  output logic phase_a,
  output logic phase_b
);
  logic [1:0] pos = 2'h0;

  // gray sequence
  // Up walks 00,10,11,01 so A leads B; one phase edge per step.
  assign phase_a = pos[0] ^ pos[1];
  assign phase_b = pos[1];

  // Steps two clocks apart: each edge is sampled alone.
  task automatic move(input bit up, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      pos <= up ? pos + 2'h1 : pos - 2'h1;
      @(posedge clock);
    end
  endtask
endmodule

// ---- dqc_pkg.sv ----
// Package with constants and carriers for the dual axis quadrature counter.
package dqc_pkg;
  // ==========================================================================
  // Widths and reset values
  // ==========================================================================
  localparam int DQC_CNT_W = 12;
  localparam logic [11:0] DQC_CNT_RST = 12'h000;
  localparam int DQC_SYNC_STAGES = 2;
  // ==========================================================================
  // Upper and lower byte field positions
  // ==========================================================================
  localparam int DQC_UB_SWF = 7;
  localparam int DQC_UB_LEFT = 6;
  localparam int DQC_UB_RIGHT = 5;
  localparam int DQC_UB_MID = 4;
  localparam int DQC_UB_CNT_HI = 3;
  localparam int DQC_LB_CNT_HI = 7;
  localparam logic [7:0] DQC_DATA_RST = 8'h00;

  typedef struct packed {
    logic phase_a;
    logic phase_b;
  } dqc_phase_s;

  typedef struct packed {
    logic right_n;
    logic left_n;
    logic middle_n;
  } dqc_keys_s;

  typedef struct packed {
    logic cs_n;
    logic axis_sel;
    logic byte_sel;
  } dqc_sel_s;
endpackage

// ---- dqc_top.sv ----
// Top of the dual axis quadrature counter with byte read port and flags.
`timescale 1ns/10ps
module dqc_top #(
  parameter int CNT_W = dqc_pkg::DQC_CNT_W
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Host read port
  input wire dqc_pkg::dqc_sel_s sel,
  input wire logic reset_horiz,
  input wire logic reset_vert,
  output logic [7:0] data_out,
  output logic data_oe,
  // Flags
  output logic count_change_flag_n,
  output logic switch_flag_n,
  // Encoder and keys
  input wire logic horiz_phase_a,
  input wire logic horiz_phase_b,
  input wire logic vert_phase_a,
  input wire logic vert_phase_b,
  input wire dqc_pkg::dqc_keys_s keys
);
  import dqc_pkg::*;

  if (CNT_W != DQC_CNT_W) begin : g_bad_width
    $error("dqc_top: byte layout serves a 12-bit count only");
  end

  logic [CNT_W-1:0] horiz_count;
  logic [CNT_W-1:0] vert_count;
  logic horiz_step;
  logic vert_step;
  dqc_sel_s sel_s1;
  dqc_sel_s sel_s2;
  logic cs_prev;
  dqc_keys_s keys_s1;
  dqc_keys_s keys_s2;
  logic [7:0] next_data;
  logic cs_fall;
  logic any_key;
  dqc_phase_s horiz_in;
  dqc_phase_s vert_in;

  assign horiz_in = '{phase_a: horiz_phase_a, phase_b: horiz_phase_b};
  assign vert_in = '{phase_a: vert_phase_a, phase_b: vert_phase_b};

  // ==========================================================================
  // Axis counters
  // ==========================================================================
  // separate axis instances
  dqc_axis #(.CNT_W(CNT_W)) u_horiz (
    .clock(clock),
    .rstn(rstn),
    .phase(horiz_in),
    .clear(reset_horiz),
    .count(horiz_count),
    .step(horiz_step)
  );

  dqc_axis #(.CNT_W(CNT_W)) u_vert (
    .clock(clock),
    .rstn(rstn),
    .phase(vert_in),
    .clear(reset_vert),
    .count(vert_count),
    .step(vert_step)
  );

  // ==========================================================================
  // Select and key synchronisers
  // ==========================================================================
  // Select lines pass through the same depth as the phases, so the byte that
  // is latched is coherent with the count steps seen by the flag logic.
  // two flop synchroniser
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sel_s1 <= '{cs_n: 1'b1, axis_sel: 1'b0, byte_sel: 1'b0};
      sel_s2 <= '{cs_n: 1'b1, axis_sel: 1'b0, byte_sel: 1'b0};
      cs_prev <= 1'b1;
      keys_s1 <= '1;
      keys_s2 <= '1;
    end else begin
      sel_s1 <= sel;
      sel_s2 <= sel_s1;
      cs_prev <= sel_s2.cs_n;
      keys_s1 <= keys;
      keys_s2 <= keys_s1;
    end
  end

  assign cs_fall = cs_prev && !sel_s2.cs_n;

  assign any_key = !keys_s2.right_n || !keys_s2.left_n || !keys_s2.middle_n;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      switch_flag_n <= 1'b1;
    end else begin
      switch_flag_n <= !any_key;
    end
  end

  // ==========================================================================
  // Byte multiplexer
  // ==========================================================================
  function automatic logic [7:0] upper_byte(input logic [CNT_W-1:0] cnt, input logic swf_n,
                                            input dqc_keys_s k);
    logic [7:0] b;
    b = DQC_DATA_RST;
    b[DQC_UB_SWF] = !swf_n;
    b[DQC_UB_LEFT] = !k.left_n;
    b[DQC_UB_RIGHT] = !k.right_n;
    b[DQC_UB_MID] = !k.middle_n;
    b[DQC_UB_CNT_HI:0] = cnt[CNT_W-1:8];
    return b;
  endfunction

  always_comb begin
    next_data = DQC_DATA_RST;
    case ({sel_s2.axis_sel, sel_s2.byte_sel})
      2'b00: next_data = horiz_count[DQC_LB_CNT_HI:0];
      2'b01: next_data = upper_byte(horiz_count, switch_flag_n, keys_s2);
      2'b10: next_data = vert_count[DQC_LB_CNT_HI:0];
      2'b11: next_data = upper_byte(vert_count, switch_flag_n, keys_s2);
      default: next_data = DQC_DATA_RST;
    endcase
  end

  // ==========================================================================
  // Output latch
  // ==========================================================================
  // The latch is transparent while deselected and freezes from the select
  // falling edge, so a mid-read change of the selects is harmless.
  // freeze at select fall
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_out <= DQC_DATA_RST;
    end else if (sel_s2.cs_n || cs_fall) begin
      data_out <= next_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= !sel_s2.cs_n;
    end
  end

  // ==========================================================================
  // Count change flag
  // ==========================================================================
  // Steps taken while selected are not flagged at all; software reads the
  // new count on its next access anyway.
  // step while deselected sets
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count_change_flag_n <= 1'b1;
    end else if (!sel_s2.cs_n) begin
      count_change_flag_n <= 1'b1;
    end else if (horiz_step || vert_step) begin
      count_change_flag_n <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_select_fall;
    cs_prev && !sel_s2.cs_n;
  endsequence

  sequence s_held_low;
    !sel_s2.cs_n [*2];
  endsequence

  // The latch loads while the synchronised select is high and on the cycle
  // that it falls, so the byte checks look one edge after such a cycle.
  sequence s_latch_open;
    sel_s2.cs_n || cs_fall;
  endsequence

  sequence s_upper_open;
    s_latch_open ##0 sel_s2.byte_sel;
  endsequence

  sequence s_read_open;
    s_select_fall ##1 !sel_s2.cs_n;
  endsequence

  a_latch_hold: assert property (@(posedge clock) disable iff (!rstn)
    s_select_fall ##1 s_held_low |=> $stable(data_out)) else $error("latched byte changed");

  a_drive_enable: assert property (@(posedge clock) disable iff (!rstn)
    ##1 data_oe == !$past(sel_s2.cs_n)) else $error("output enable wrong");

  a_flag_cleared: assert property (@(posedge clock) disable iff (!rstn)
    !sel_s2.cs_n |=> count_change_flag_n) else $error("flag low during select");

  a_flag_set: assert property (@(posedge clock) disable iff (!rstn)
    (sel_s2.cs_n && (horiz_step || vert_step)) |=> !count_change_flag_n)
    else $error("step did not set flag");

  a_switch_flag: assert property (@(posedge clock) disable iff (!rstn)
    any_key |=> !switch_flag_n) else $error("switch flag missed key");

  a_latch_track: assert property (@(posedge clock) disable iff (!rstn)
    sel_s2.cs_n |=> data_out == $past(next_data)) else $error("latch not tracking");

  a_status_bit: assert property (@(posedge clock) disable iff (!rstn)
    s_upper_open |=> data_out[DQC_UB_SWF] == !$past(switch_flag_n))
    else $error("status bit mismatch");

  // ==========================================================================
  // Byte and flag detail checks
  // ==========================================================================
  // A mid-read change of the selects must never reach the pins; the freeze
  // check covers every cycle of a read after the fall has been taken.
  // latch takes chosen byte
  a_latch_load: assert property (@(posedge clock) disable iff (!rstn)
    s_select_fall |=> data_out == $past(next_data))
    else $error("byte not latched at select fall");

  a_latch_freeze: assert property (@(posedge clock) disable iff (!rstn)
    (!sel_s2.cs_n && !cs_fall) |=> $stable(data_out))
    else $error("latched byte moved during read");

  a_oe_drive: assert property (@(posedge clock) disable iff (!rstn)
    !sel_s2.cs_n |=> data_oe)
    else $error("bus not driven while selected");

  a_oe_release: assert property (@(posedge clock) disable iff (!rstn)
    sel_s2.cs_n |=> !data_oe)
    else $error("bus driven while deselected");

  a_read_open: assert property (@(posedge clock) disable iff (!rstn)
    s_read_open |-> (data_oe && count_change_flag_n))
    else $error("read opened without drive or with flag low");

  a_flag_steady: assert property (@(posedge clock) disable iff (!rstn)
    (sel_s2.cs_n && !horiz_step && !vert_step) |=> $stable(count_change_flag_n))
    else $error("flag moved without step");

  a_key_release: assert property (@(posedge clock) disable iff (!rstn)
    !any_key |=> switch_flag_n)
    else $error("switch flag low with no key");

  a_lower_horiz: assert property (@(posedge clock) disable iff (!rstn)
    s_latch_open ##0 (!sel_s2.axis_sel && !sel_s2.byte_sel) |=>
    data_out == $past(horiz_count[DQC_LB_CNT_HI:0]))
    else $error("lower X byte wrong");

  a_lower_vert: assert property (@(posedge clock) disable iff (!rstn)
    s_latch_open ##0 (sel_s2.axis_sel && !sel_s2.byte_sel) |=>
    data_out == $past(vert_count[DQC_LB_CNT_HI:0]))
    else $error("lower Y byte wrong");

  a_upper_horiz: assert property (@(posedge clock) disable iff (!rstn)
    s_upper_open ##0 !sel_s2.axis_sel |=>
    data_out[DQC_UB_CNT_HI:0] == $past(horiz_count[CNT_W-1:8]))
    else $error("upper X nibble wrong");

  a_upper_vert: assert property (@(posedge clock) disable iff (!rstn)
    s_upper_open ##0 sel_s2.axis_sel |=>
    data_out[DQC_UB_CNT_HI:0] == $past(vert_count[CNT_W-1:8]))
    else $error("upper Y nibble wrong");

  a_key_left: assert property (@(posedge clock) disable iff (!rstn)
    s_upper_open |=> data_out[DQC_UB_LEFT] == !$past(keys_s2.left_n))
    else $error("left key bit wrong");

  a_key_right: assert property (@(posedge clock) disable iff (!rstn)
    s_upper_open |=> data_out[DQC_UB_RIGHT] == !$past(keys_s2.right_n))
    else $error("right key bit wrong");

  a_key_middle: assert property (@(posedge clock) disable iff (!rstn)
    s_upper_open |=> data_out[DQC_UB_MID] == !$past(keys_s2.middle_n))
    else $error("middle key bit wrong");

  a_horiz_alone: assert property (@(posedge clock) disable iff (!rstn)
    $changed(horiz_count) |-> (horiz_step || $past(reset_horiz)))
    else $error("X count moved without X step or clear");

  a_vert_alone: assert property (@(posedge clock) disable iff (!rstn)
    $changed(vert_count) |-> (vert_step || $past(reset_vert)))
    else $error("Y count moved without Y step or clear");

  a_step_horiz: assert property (@(posedge clock) disable iff (!rstn)
    (horiz_step && !$past(reset_horiz)) |-> $changed(horiz_count))
    else $error("X step left count unchanged");

  a_step_vert: assert property (@(posedge clock) disable iff (!rstn)
    (vert_step && !$past(reset_vert)) |-> $changed(vert_count))
    else $error("Y step left count unchanged");
endmodule

// ---- dqc_top_test.sv ----
// Self-checking bench for the dual axis quadrature counter.
`timescale 1ns/10ps
module dqc_top_test;
  import dqc_pkg::*;
  // ==========================================================================
  // Stimulus and observation
  // ==========================================================================
  logic clock = 1'b0;
  logic rstn = 1'b0;
  dqc_sel_s sel = '{1'b1, 1'b0, 1'b0};
  logic reset_horiz = 1'b0;
  logic reset_vert = 1'b0;
  dqc_keys_s keys = '{1'b1, 1'b1, 1'b1};
  logic [7:0] data_out;
  logic data_oe;
  logic count_change_flag_n;
  logic switch_flag_n;
  logic hpa, hpb, vpa, vpb;
  wire [7:0] data_bus = data_oe ? data_out : 8'hZZ;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  localparam logic [7:0] KEY_EXP [3] = '{8'h90, 8'hC0, 8'hA0};

  always #20 clock = ~clock;

  dqc_enc_model henc (.clock(clock), .phase_a(hpa), .phase_b(hpb));
  dqc_enc_model venc (.clock(clock), .phase_a(vpa), .phase_b(vpb));

  dqc_top dut (.clock(clock), .rstn(rstn), .sel(sel), .reset_horiz(reset_horiz),
    .reset_vert(reset_vert), .data_out(data_out), .data_oe(data_oe),
    .count_change_flag_n(count_change_flag_n), .switch_flag_n(switch_flag_n),
    .horiz_phase_a(hpa), .horiz_phase_b(hpb), .vert_phase_a(vpa), .vert_phase_b(vpb),
    .keys(keys));

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic close_out();
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // select held low for the whole read
  // With flip, axis select turns mid-read and a Y step arrives.
  task automatic rd(input logic ax, input logic by, input logic [7:0] exp, input bit flip);
    int n;
    @(posedge clock);
    sel <= '{1'b0, ax, by};
    for (n = 0; n < 10 && data_oe !== 1'b1; n++) settle(1);
    chk(data_bus, exp);
    if (flip) begin
      @(posedge clock);
      sel.axis_sel <= ~ax;
      venc.move(1'b1, 1);
      settle(6);
      chk(data_bus, exp);
    end
    chk({7'h00, count_change_flag_n}, 8'h01);
    @(posedge clock);
    sel.cs_n <= 1'b1;
    settle(5);
    chk({7'h00, data_oe}, 8'h00);
    chk(data_bus, 8'hZZ);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    settle(2);
    chk({6'h00, count_change_flag_n, switch_flag_n}, 8'h03);
    rd(1'b0, 1'b0, 8'h00, 1'b0);
    henc.move(1'b1, 5);
    settle(8);
    chk({7'h00, count_change_flag_n}, 8'h00);
    rd(1'b0, 1'b0, 8'h05, 1'b0);
    henc.move(1'b0, 7);
    settle(8);
    rd(1'b0, 1'b0, 8'hFE, 1'b0);
    rd(1'b0, 1'b1, 8'h0F, 1'b0);
    venc.move(1'b1, 3);
    henc.move(1'b1, 2);
    settle(8);
    // The Y step made during the read must not raise the flag.
    rd(1'b0, 1'b0, 8'h00, 1'b1);
    chk({7'h00, count_change_flag_n}, 8'h01);
    rd(1'b0, 1'b1, 8'h00, 1'b0);
    rd(1'b1, 1'b0, 8'h04, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      keys <= ~(3'h1 << i);
      settle(6);
      chk({7'h00, switch_flag_n}, 8'h00);
      rd(1'b1, 1'b1, KEY_EXP[i], 1'b0);
      @(posedge clock);
      keys <= 3'h7;
      settle(6);
      chk({7'h00, switch_flag_n}, 8'h01);
    end
    henc.move(1'b1, 3);
    settle(8);
    @(posedge clock);
    reset_horiz <= 1'b1;
    repeat (2) @(posedge clock);
    reset_horiz <= 1'b0;
    settle(3);
    rd(1'b0, 1'b0, 8'h00, 1'b0);
    rd(1'b1, 1'b0, 8'h04, 1'b0);
    @(posedge clock);
    reset_vert <= 1'b1;
    repeat (2) @(posedge clock);
    reset_vert <= 1'b0;
    settle(3);
    rd(1'b1, 1'b0, 8'h00, 1'b0);
    close_out();
  end
endmodule
